// ===== core/audio_channel_slot_mapper.sv
// per-channel slot and output line mapping for the serial audio port
`include "slot_mapper_map.svh"
`default_nettype none
module audio_channel_slot_mapper #(
	parameter int CHANNELS = 4,
	parameter int SAMPLE_BITS = 16
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire slot_mapper_pkg::apb_addr_t paddr,
	input wire slot_mapper_pkg::apb_data_t pwdata,
	output slot_mapper_pkg::apb_data_t prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_bit_clock,
	input wire logic frame_sync,
	input wire logic [SAMPLE_BITS-1:0] chan_sample [CHANNELS],
	output logic primary_data_out,
	output logic primary_data_oe,
	output logic multipurpose_pin_one_out,
	output logic multipurpose_pin_one_oe
);
	import slot_mapper_pkg::*;
	localparam int BW = $clog2(SAMPLE_BITS);
	localparam slot_t SLOT_RESET [4] = '{`CHAN1_SLOT_RESET, `CHAN2_SLOT_RESET,
		`CHAN3_SLOT_RESET, `CHAN4_SLOT_RESET};
	if (CHANNELS != 4 || SAMPLE_BITS < 2 || SAMPLE_BITS > 32) begin : g_bad_params
		$error("slot mapper serves four channels of 2 to 32 bits");
	end
	////////////////////////////////////////////////////////////////////////////
	// registers and apb slave
	slot_t slot_reg [CHANNELS], slot_next [CHANNELS];
	logic line_reg [CHANNELS], line_next [CHANNELS];
	logic [2:0] ctrl_reg, ctrl_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	apb_data_t prdata_reg, prdata_next;
	logic [9:0] idx;
	logic hit_chan, hit_ctrl, hit_stat, mapped;
	logic [1:0] chan_sel;
	logic fill_hiz;
	fmt_e fmt;
	logic frame_seen_reg, half_reg;
	logic [6:0] slot_cnt_reg;
	assign idx = paddr[11:2];
	assign hit_chan = paddr[1:0] == 2'h0 && idx >= 10'(`IDX_CHAN1_SLOT_CONFIG)
		&& idx <= 10'(`IDX_CHAN4_SLOT_CONFIG);
	assign hit_ctrl = paddr[1:0] == 2'h0 && idx == 10'(`IDX_PORT_CONTROL);
	assign hit_stat = paddr[1:0] == 2'h0 && idx == 10'(`IDX_PORT_STATUS);
	assign mapped = hit_chan || hit_ctrl || hit_stat;
	assign chan_sel = 2'(idx - 10'(`IDX_CHAN1_SLOT_CONFIG));
	assign fill_hiz = ctrl_reg[`CTRL_FILL_HIZ_BIT];
	assign fmt = fmt_e'(ctrl_reg[`CTRL_FMT_MSB:`CTRL_FMT_LSB]);
	always_comb begin
		slot_next = slot_reg;
		line_next = line_reg;
		ctrl_next = ctrl_reg;
		// answer one cycle into the access phase
		pready_next = psel && penable && !pready_reg;
		pslverr_next = pready_next && !mapped;
		prdata_next = prdata_reg;
		if (pready_next && !pwrite) begin
			prdata_next = '0;
			if (hit_chan) begin
				// bit 7 and above read zero
				prdata_next[`SLOT_FIELD_MSB:`SLOT_FIELD_LSB] = slot_reg[chan_sel];
				prdata_next[`LINE_SELECT_BIT] = line_reg[chan_sel];
			end else if (hit_ctrl) begin
				prdata_next[2:0] = ctrl_reg;
			end else if (hit_stat) begin
				prdata_next[`STAT_FRAME_SEEN_BIT] = frame_seen_reg;
				prdata_next[`STAT_SLOT_MSB:`STAT_SLOT_LSB] = slot_cnt_reg;
				prdata_next[`STAT_HALF_BIT] = half_reg;
			end
		end
		if (psel && penable && pready_reg && pwrite) begin
			if (hit_chan) begin
				slot_next[chan_sel] = pwdata[`SLOT_FIELD_MSB:`SLOT_FIELD_LSB];
				line_next[chan_sel] = pwdata[`LINE_SELECT_BIT];
			end else if (hit_ctrl) begin
				ctrl_next = pwdata[2:0];
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < CHANNELS; i++) begin
				slot_reg[i] <= SLOT_RESET[i];
				line_reg[i] <= `LINE_SELECT_RESET;
			end
			ctrl_reg <= `CTRL_RESET;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else begin
			slot_reg <= slot_next;
			line_reg <= line_next;
			ctrl_reg <= ctrl_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
		end
	end
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;
	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detection
	logic [2:0] bclk_sync_reg, fs_sync_reg;
	logic bclk_rise, bclk_fall;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bclk_sync_reg <= 3'h0;
			fs_sync_reg <= 3'h0;
		end else begin
			bclk_sync_reg <= {bclk_sync_reg[1:0], serial_bit_clock};
			fs_sync_reg <= {fs_sync_reg[1:0], frame_sync};
		end
	end
	assign bclk_rise = bclk_sync_reg[1] && !bclk_sync_reg[2];
	assign bclk_fall = !bclk_sync_reg[1] && bclk_sync_reg[2];
	////////////////////////////////////////////////////////////////////////////
	// slot and bit counters, advanced on the transmit (falling) edge
	logic fs_prev_reg, fs_prev_next;
	logic start_pend_reg, start_pend_next;
	logic start_half_reg, start_half_next;
	logic [BW-1:0] bit_cnt_reg, bit_cnt_next;
	logic [6:0] slot_cnt_next;
	logic half_next, frame_seen_next;
	logic fs_now;
	assign fs_now = fs_sync_reg[1];
	always_comb begin
		fs_prev_next = fs_prev_reg;
		start_pend_next = start_pend_reg;
		start_half_next = start_half_reg;
		bit_cnt_next = bit_cnt_reg;
		slot_cnt_next = slot_cnt_reg;
		half_next = half_reg;
		frame_seen_next = frame_seen_reg;
		if (bclk_rise) begin
			fs_prev_next = fs_now;
			if (fmt == fmt_tdm ? (fs_now && !fs_prev_reg) : (fs_now != fs_prev_reg)) begin
				start_pend_next = 1'b1;
				// left-justified: high is left; i2s: low is left
				start_half_next = (fmt == fmt_i2s) ? fs_now : !fs_now;
			end
		end
		if (bclk_fall) begin
			if (start_pend_reg) begin
				start_pend_next = 1'b0;
				bit_cnt_next = '0;
				slot_cnt_next = 7'h00;
				half_next = (fmt == fmt_tdm) ? 1'b0 : start_half_reg;
				frame_seen_next = 1'b1;
			end else if (int'(bit_cnt_reg) == SAMPLE_BITS - 1) begin
				bit_cnt_next = '0;
				if (!slot_cnt_reg[6]) begin
					slot_cnt_next = slot_cnt_reg + 7'h01;
				end
			end else begin
				bit_cnt_next = bit_cnt_reg + BW'(1);
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fs_prev_reg <= 1'b0;
			start_pend_reg <= 1'b0;
			start_half_reg <= 1'b0;
			bit_cnt_reg <= '0;
			slot_cnt_reg <= 7'h40;
			half_reg <= 1'b0;
			frame_seen_reg <= 1'b0;
		end else begin
			fs_prev_reg <= fs_prev_next;
			start_pend_reg <= start_pend_next;
			start_half_reg <= start_half_next;
			bit_cnt_reg <= bit_cnt_next;
			slot_cnt_reg <= slot_cnt_next;
			half_reg <= half_next;
			frame_seen_reg <= frame_seen_next;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// effective slot and per-line bit selection
	slot_t eff_slot;
	logic eff_valid;
	logic [1:0] line_hit, line_bit;
	always_comb begin
		if (fmt == fmt_tdm) begin
			eff_slot = slot_cnt_next[5:0];
			eff_valid = frame_seen_next && !slot_cnt_next[6];
		end else begin
			// slot field bit 5 selects the right half
			eff_slot = {half_next, slot_cnt_next[4:0]};
			eff_valid = frame_seen_next && slot_cnt_next < 7'(`HALF_SLOTS);
		end
	end
	genvar l;
	generate
		for (l = 0; l < 2; l++) begin : g_line
			slot_bit_picker #(
				.CHANNELS(CHANNELS),
				.SAMPLE_BITS(SAMPLE_BITS)
			) u_picker (
				.line_id(1'(l)),
				.cur_slot(eff_slot),
				.cur_valid(eff_valid),
				.bit_idx(bit_cnt_next),
				.chan_slot(slot_reg),
				.chan_line(line_reg),
				.chan_sample(chan_sample),
				.hit(line_hit[l]),
				.bit_out(line_bit[l])
			);
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////////
	// output pins, updated on the transmit edge
	logic [1:0] dout_reg, dout_next, doe_reg, doe_next;
	always_comb begin
		dout_next = dout_reg;
		doe_next = doe_reg;
		if (bclk_fall) begin
			for (int k = 0; k < 2; k++) begin
				if (line_hit[k]) begin
					dout_next[k] = line_bit[k];
					doe_next[k] = 1'b1;
				end else begin
					dout_next[k] = 1'b0;
					doe_next[k] = !fill_hiz;
				end
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dout_reg <= 2'h0;
			doe_reg <= 2'h3;
		end else begin
			dout_reg <= dout_next;
			doe_reg <= doe_next;
		end
	end
	assign primary_data_out = dout_reg[0];
	assign primary_data_oe = doe_reg[0];
	assign multipurpose_pin_one_out = dout_reg[1];
	assign multipurpose_pin_one_oe = doe_reg[1];
	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	primary_line_a: assert property (bclk_fall && line_hit[0] |=>
		primary_data_oe && primary_data_out == $past(line_bit[0]))
		else $error("primary pin missed its channel bit");
	second_line_a: assert property (bclk_fall && line_hit[1] |=>
		multipurpose_pin_one_oe && multipurpose_pin_one_out == $past(line_bit[1]))
		else $error("secondary pin missed its channel bit");
	reserved_zero_a: assert property (pready && !$past(pwrite) && $past(hit_chan) |->
		prdata[31:7] == 25'h0)
		else $error("channel config upper bits not zero");
	tdm_slot_a: assert property (bclk_fall && fmt == fmt_tdm && frame_seen_next
		&& !slot_cnt_next[6] && !line_reg[0] && slot_reg[0] == slot_cnt_next[5:0]
		|-> line_hit[0])
		else $error("tdm slot index mismatch");
	left_half_a: assert property (bclk_fall && fmt != fmt_tdm && !half_next
		&& frame_seen_next && slot_cnt_next < 7'(`HALF_SLOTS) && !line_reg[3]
		&& {1'b0, slot_reg[3]} == slot_cnt_next |-> line_hit[0])
		else $error("left half slot mismatch");
	right_half_a: assert property (bclk_fall && fmt != fmt_tdm && half_next
		&& frame_seen_next && slot_cnt_next < 7'(`HALF_SLOTS) && !line_reg[1]
		&& {1'b0, slot_reg[1]} == slot_cnt_next + 7'(`HALF_SLOTS) |-> line_hit[0])
		else $error("right half slot mismatch");
	reset_slot_a: assert property (disable iff (1'b0) $past(rst) |->
		slot_reg[0] == 6'h00 && slot_reg[1] == 6'h01 && slot_reg[2] == 6'h02
		&& slot_reg[3] == 6'h03 && !line_reg[0] && !line_reg[3])
		else $error("channel slot reset value wrong");
	fill_mode_a: assert property (bclk_fall && !line_hit[0] |=>
		!primary_data_out && primary_data_oe == !$past(fill_hiz))
		else $error("unused cycle fill wrong");
	tdm_frame_c: cover property (fmt == fmt_tdm && bclk_fall && line_hit[0]);
	right_half_c: cover property (fmt == fmt_i2s && half_next && line_hit[0]);
	second_pin_c: cover property (bclk_fall && line_hit[1] && fill_hiz);
endmodule : audio_channel_slot_mapper
`default_nettype wire

// ===== core/slot_bit_picker.sv
// picks the bit that one output line carries in the current slot
`default_nettype none
module slot_bit_picker #(
	parameter int CHANNELS = 4,
	parameter int SAMPLE_BITS = 16
) (
	input wire logic line_id,
	input wire slot_mapper_pkg::slot_t cur_slot,
	input wire logic cur_valid,
	input wire logic [$clog2(SAMPLE_BITS)-1:0] bit_idx,
	input wire slot_mapper_pkg::slot_t chan_slot [CHANNELS],
	input wire logic chan_line [CHANNELS],
	input wire logic [SAMPLE_BITS-1:0] chan_sample [CHANNELS],
	output logic hit,
	output logic bit_out
);
	import slot_mapper_pkg::*;

	if (CHANNELS < 1 || SAMPLE_BITS < 2) begin : g_bad_params
		$error("slot picker needs one channel and two sample bits");
	end

	logic [CHANNELS-1:0] match;

	// lowest channel wins if software maps two channels to one slot
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_match
			assign match[g] = cur_valid && chan_line[g] == line_id && chan_slot[g] == cur_slot;
		end
	endgenerate

	always_comb begin
		hit = |match;
		bit_out = 1'b0;
		for (int i = CHANNELS - 1; i >= 0; i--) begin
			if (match[i]) begin
				bit_out = chan_sample[i][SAMPLE_BITS - 1 - int'(bit_idx)];
			end
		end
	end
endmodule : slot_bit_picker
`default_nettype wire

// ===== core/slot_mapper_map.svh
// register indices, field positions and reset values of the slot mapper
`ifndef SLOT_MAPPER_MAP_SVH
`define SLOT_MAPPER_MAP_SVH

`define IDX_CHAN1_SLOT_CONFIG 8'h0b
`define IDX_CHAN2_SLOT_CONFIG 8'h0c
`define IDX_CHAN3_SLOT_CONFIG 8'h0d
`define IDX_CHAN4_SLOT_CONFIG 8'h0e
`define IDX_PORT_CONTROL 8'h20
`define IDX_PORT_STATUS 8'h21

`define SLOT_FIELD_LSB 0
`define SLOT_FIELD_MSB 5
`define LINE_SELECT_BIT 6

`define CTRL_FILL_HIZ_BIT 0
`define CTRL_FMT_LSB 1
`define CTRL_FMT_MSB 2
`define CTRL_RESET 3'h0

`define STAT_FRAME_SEEN_BIT 0
`define STAT_SLOT_LSB 1
`define STAT_SLOT_MSB 7
`define STAT_HALF_BIT 8

`define LINE_SELECT_RESET 1'h0
`define CHAN1_SLOT_RESET 6'h00
`define CHAN2_SLOT_RESET 6'h01
`define CHAN3_SLOT_RESET 6'h02
`define CHAN4_SLOT_RESET 6'h03
`define HALF_SLOTS 6'h20

`endif

// ===== core/slot_mapper_pkg.sv
// types shared by the slot mapper files
`default_nettype none
package slot_mapper_pkg;
	typedef enum logic [1:0] {fmt_tdm, fmt_left_justified, fmt_i2s} fmt_e;
	typedef logic [5:0] slot_t;
	typedef logic [11:0] apb_addr_t;
	typedef logic [31:0] apb_data_t;
endpackage : slot_mapper_pkg
`default_nettype wire

// ===== tb/audio_channel_slot_mapper_test.sv
// register and serial frame checks of the slot mapper
`include "slot_mapper_map.svh"
`default_nettype none
module audio_channel_slot_mapper_test;
	timeunit 1ns;
	timeprecision 1ps;
	import slot_mapper_pkg::*;
	localparam int SB = 4;
	logic core_clk;
	logic rst;
	logic psel;
	logic penable;
	logic pwrite;
	apb_addr_t paddr;
	apb_data_t pwdata;
	apb_data_t prdata;
	logic pready;
	logic pslverr;
	logic bclk;
	logic fsync;
	logic [SB-1:0] smp [4];
	logic pdo, poe, sdo, soe;
	int n_mismatch;
	int samples_checked;
	int cycles;
	logic [5:0] cfg_slot [4];
	logic cfg_line [4];
	logic hiz;
	apb_data_t rd;
	logic er;
	audio_channel_slot_mapper #(.CHANNELS(4), .SAMPLE_BITS(SB)) dut_u (
		.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_bit_clock(bclk), .frame_sync(fsync), .chan_sample(smp),
		.primary_data_out(pdo), .primary_data_oe(poe),
		.multipurpose_pin_one_out(sdo), .multipurpose_pin_one_oe(soe));
	serial_host_model #(.SB(SB), .H(8)) host_u (
		.core_clk(core_clk), .bclk(bclk), .fsync(fsync),
		.pdo(pdo), .poe(poe), .sdo(sdo), .soe(soe));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_mismatch = n_mismatch + 1;
			end_of_test();
		end
	end
	////////////////////////////////
	task automatic end_of_test();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input apb_data_t got, input apb_data_t exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input int idx, input apb_data_t d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= apb_addr_t'(4 * idx);
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic set_chan(input int c, input logic [5:0] s, input logic ln);
		cfg_slot[c] = s;
		cfg_line[c] = ln;
		apb(1'b1, `IDX_CHAN1_SLOT_CONFIG + c, apb_data_t'({ln, s}));
	endtask : set_chan
	task automatic set_ctrl(input fmt_e f, input logic hz);
		hiz = hz;
		apb(1'b1, `IDX_PORT_CONTROL, apb_data_t'({f, hz}));
	endtask : set_ctrl
	// k[6] picks the pin, k[5:0] the captured slot position
	task automatic check_frame();
		int k;
		int c;
		logic [SB-1:0] ew;
		logic [SB-1:0] eo;
		for (k = 0; k < 128; k++) begin
			ew = '0;
			eo = hiz ? '0 : '1;
			for (c = 3; c >= 0; c--) begin
				if (cfg_line[c] == k[6] && cfg_slot[c] == k[5:0]) begin
					ew = smp[c];
					eo = '1;
				end
			end
			chk(apb_data_t'(k[6] ? host_u.se[k[5:0]] : host_u.pe[k[5:0]]), apb_data_t'(eo));
			if (eo !== '0) begin
				chk(apb_data_t'(k[6] ? host_u.sw[k[5:0]] : host_u.pw[k[5:0]]), apb_data_t'(ew));
			end
		end
	endtask : check_frame
	////////////////////////////////
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		smp[0] = 4'h9;
		smp[1] = 4'h6;
		smp[2] = 4'hc;
		smp[3] = 4'h3;
		hiz = 1'b0;
		cycles = 0;
		n_mismatch = 0;
		samples_checked = 0;
		for (int c = 0; c < 4; c++) begin
			cfg_slot[c] = 6'(c);
			cfg_line[c] = 1'b0;
		end
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		for (int c = 0; c < 4; c++) begin
			apb(1'b0, `IDX_CHAN1_SLOT_CONFIG + c, '0);
			chk(rd, apb_data_t'(c));
		end
		host_u.run_half(1'b1, 1'b1, 64, 0);
		check_frame();
		apb(1'b1, `IDX_CHAN1_SLOT_CONFIG, 32'hffff_ffff);
		apb(1'b0, `IDX_CHAN1_SLOT_CONFIG, '0);
		chk(rd, 32'h0000_007f);
		apb(1'b0, `IDX_PORT_STATUS, '0);
		chk(rd, 32'h0000_0081);
		apb(1'b1, 8'hff, 32'h0000_0055);
		apb(1'b0, 8'hff, '0);
		chk({rd[31:1], er}, 32'h0000_0001);
		// distinct slots on each pin keep frames free of collisions
		set_ctrl(fmt_tdm, 1'b1);
		set_chan(0, 6'h3f, 1'b0);
		set_chan(1, 6'h00, 1'b1);
		set_chan(2, 6'h1f, 1'b0);
		set_chan(3, 6'h20, 1'b1);
		host_u.run_half(1'b1, 1'b1, 64, 0);
		check_frame();
		set_ctrl(fmt_left_justified, 1'b0);
		set_chan(0, 6'h1f, 1'b1);
		set_chan(1, 6'h20, 1'b0);
		set_chan(2, 6'h3f, 1'b1);
		set_chan(3, 6'h00, 1'b0);
		host_u.run_half(1'b1, 1'b0, 32, 0);
		host_u.run_half(1'b0, 1'b0, 32, 32);
		check_frame();
		set_ctrl(fmt_i2s, 1'b1);
		apb(1'b0, `IDX_PORT_CONTROL, '0);
		chk(rd, 32'h0000_0005);
		apb(1'b0, `IDX_PORT_STATUS, '0);
		chk(rd, 32'h0000_0141);
		host_u.run_half(1'b1, 1'b0, 32, 32);
		host_u.run_half(1'b0, 1'b0, 32, 0);
		check_frame();
		end_of_test();
	end
endmodule : audio_channel_slot_mapper_test
`default_nettype wire

// ===== tb/serial_host_model.sv
// behavioural host that clocks serial frames and captures both data pins
`default_nettype none
module serial_host_model #(
	parameter int SB = 4,
	parameter int H = 8
) (
	input wire logic core_clk,
	output logic bclk,
	output logic fsync,
	input wire logic pdo,
	input wire logic poe,
	input wire logic sdo,
	input wire logic soe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [SB-1:0] pw [64];
	logic [SB-1:0] pe [64];
	logic [SB-1:0] sw [64];
	logic [SB-1:0] se [64];
	initial begin
		bclk = 1'b0;
		fsync = 1'b0;
	end
	////////////////////////////////
	// bit clock stands low outside a half; words land at base .. base+n-1
	task automatic run_half(input logic lvl, input logic pulse, input int n, input int base);
		int i;
		int b;
		fsync <= lvl;
		repeat (H) @(posedge core_clk);
		bclk <= 1'b1;
		repeat (H) @(posedge core_clk);
		bclk <= 1'b0;
		if (pulse) begin
			fsync <= 1'b0;
		end
		for (i = base; i < base + n; i++) begin
			for (b = SB - 1; b >= 0; b--) begin
				repeat (H) @(posedge core_clk);
				bclk <= 1'b1;
				pw[i][b] = pdo;
				pe[i][b] = poe;
				sw[i][b] = sdo;
				se[i][b] = soe;
				repeat (H) @(posedge core_clk);
				bclk <= 1'b0;
			end
		end
	endtask : run_half
endmodule : serial_host_model
`default_nettype wire
